// [ddr4_ca_defines.vh]
// Constants for the command and address input decoder.
`ifndef DDR4_CA_DEFINES_VH
`define DDR4_CA_DEFINES_VH
// Address bit positions with a second function.
`define AP_BIT 10
`define BC_BIT 12
// Command codes {ras_n, cas_n, we_n} with act_n high.
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_RSV 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_ZQC 3'h6
`define CMD_NOP 3'h7
// Power states.
`define PS_ACTIVE 2'h0
`define PS_PRE_PD 2'h1
`define PS_ACT_PD 2'h2
`define PS_SELF_REF 2'h3
`endif

// [ddr4_ca_decode.v]
// Command, address and control input decoder of a DDR4 memory device.
`include "ddr4_ca_defines.vh"

module ddr4_ca_decode #(
   parameter ADDR_W = 18,  // Address inputs, bits 16..14 shared with command pins.
   parameter BG_W = 2,     // Bank group bits; a x16 part uses 1.
   parameter BA_W = 2,     // Bank address bits.
   parameter IS_X8 = 1     // Termination strobe pair exists only on the x8 part.
) (
   input wire clock,                  // Core clock, true clock crossing.
   input wire srst,                   // Synchronous reset, active high.
   input wire cke_pin,                // Clock enable from the controller.
   input wire cs_n,                   // Chip select, active low.
   input wire act_n,                  // Activate, active low.
   input wire ras_n,                  // Command pin or row bit 16.
   input wire cas_n,                  // Command pin or row bit 15.
   input wire we_n,                   // Command pin or row bit 14.
   input wire [ADDR_W-1:0] addr,      // Address inputs.
   input wire [BA_W-1:0] ba,          // Bank address.
   input wire [BG_W-1:0] bg,          // Bank group.
   input wire odt,                    // Termination control.
   input wire rtt_nom_en,             // Nominal termination enabled by mode setting.
   input wire tdqs_en,                // Termination strobe function enabled.
   input wire any_bank_open,          // Some bank holds an open row.
   input wire self_refresh_req,       // Refresh command came with clock enable low.
   output reg cmd_valid,              // One-cycle pulse, decoded command.
   output reg cmd_act,                // Command is activate.
   output reg [2:0] cmd_code,         // Non-activate command code.
   output reg [BA_W-1:0] cmd_bank,    // Target bank or mode register low bits.
   output reg [BG_W-1:0] cmd_group,   // Target bank group.
   output reg [2:0] mr_sel,           // Mode register selected on mode set.
   output reg [17:0] row_addr,        // Row address on activate.
   output reg [9:0] col_addr,         // Column address on read or write.
   output reg [17:0] opcode,          // Op-code on mode set.
   output reg auto_pre,               // Read or write closes bank afterwards.
   output reg burst_chop,             // Read or write is chopped.
   output reg pre_all,                // Precharge closes every bank.
   output reg rtt_nom_on,             // Nominal termination applied to data pins.
   output reg rtt_tdqs_on,            // Nominal termination applied to the strobe pair.
   output reg clk_run,                // Internal clocks and command buffers enabled.
   output reg odt_buf_on,             // Termination control buffer enabled.
   output reg drv_on,                 // Output drivers enabled.
   output reg [1:0] power_state       // Present power state.
);

   ////////////////////////////////////////////////////////////////////////////
   // Clock enable crosses from the pin; the asynchronous exit needs no command edge.

   reg cke_s1;
   reg cke_s2;
   reg cke_s3;
   reg cke;
   reg [1:0] next_state;

   // Three stages; the first may go metastable, so only the later two are compared.
   always @(posedge clock) begin
      cke_s1 <= cke_pin;
      cke_s2 <= cke_s1;
      cke_s3 <= cke_s2;
   end

   wire cke_agree = (cke_s2 == cke_s3);

   // Clock enable is filtered on its own, so leaving self refresh needs no sampled command.
   always @(posedge clock) begin
      if (srst) begin
         cke <= 1'b1;
      end else if (cke_agree) begin
         cke <= cke_s3;
      end
   end

   always @* begin
      next_state = power_state;
      case (power_state)
         `PS_ACTIVE: begin
            // A row left open rules out precharge power-down and self refresh.
            if (!cke) begin
               next_state = sleep_target(any_bank_open, self_refresh_req);
            end
         end
         // Every sleep state leaves on clock enable alone; no command is needed.
         `PS_PRE_PD: begin
            if (cke) begin
               next_state = `PS_ACTIVE;
            end
         end
         `PS_ACT_PD: begin
            if (cke) begin
               next_state = `PS_ACTIVE;
            end
         end
         `PS_SELF_REF: begin
            if (cke) begin
               next_state = `PS_ACTIVE;
            end
         end
         default: begin
            next_state = `PS_ACTIVE;
         end
      endcase
   end

   always @(posedge clock) begin
      if (srst) begin
         power_state <= `PS_ACTIVE;
      end else begin
         power_state <= next_state;
      end
   end

   always @* begin
      // Commands and drivers run only while awake with clock enable still high.
      clk_run = (power_state == `PS_ACTIVE) && cke;
      drv_on = clk_run;
      // The termination control buffer survives power-down but not self refresh.
      odt_buf_on = (power_state != `PS_SELF_REF);
   end

   // Input buffers. A buffer that is off shows its idle level, so pins left floating
   // while the part sleeps can never be read as a command.
   wire cs_in_n = cs_n || !clk_run;
   wire act_in_n = act_n || !clk_run;
   wire ras_in_n = ras_n || !clk_run;
   wire cas_in_n = cas_n || !clk_run;
   wire we_in_n = we_n || !clk_run;
   wire [ADDR_W-1:0] addr_in = addr & {ADDR_W{clk_run}};
   wire [BA_W-1:0] ba_in = ba & {BA_W{clk_run}};
   wire [BG_W-1:0] bg_in = bg & {BG_W{clk_run}};
   // The termination control keeps its buffer through power-down, not self refresh.
   wire odt_in = odt && odt_buf_on;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers shared by the state machine, the strobe and the field capture.
   // The strobe is gated by asks_work but the fields by chip select alone, so a selected
   // no-operation updates the captured code and fields without raising the strobe.

   // An open row forces active power-down; otherwise the refresh request picks the state.
   function [1:0] sleep_target;
      input open_row;
      input refresh_req;
      begin
         if (open_row) begin
            sleep_target = `PS_ACT_PD;
         end else if (refresh_req) begin
            sleep_target = `PS_SELF_REF;
         end else begin
            sleep_target = `PS_PRE_PD;
         end
      end
   endfunction

   // A selected cycle asks for work if it is an activate or its code is not no-operation.
   function asks_work;
      input is_act;
      input [2:0] code;
      begin
         asks_work = is_act || (code != `CMD_NOP);
      end
   endfunction

   // The code reported for a command; an activate reports no-operation.
   function [2:0] code_of;
      input is_act;
      input [2:0] code;
      begin
         code_of = is_act ? `CMD_NOP : code;
      end
   endfunction

   // On activate the three command pins stand for row bits 16, 15 and 14.
   function [17:0] row_of;
      input [17:0] a;
      input [2:0] code;
      begin
         row_of = {a[17], code, a[13:0]};
      end
   endfunction

   // The op-code is the low address; the pins shared with the command are not part of it.
   function [17:0] opcode_of;
      input [17:0] a;
      begin
         opcode_of = {4'h0, a[13:0]};
      end
   endfunction

   // Column commands are the only ones that carry the chop bit; precharge also reads the precharge bit.
   function is_column;
      input [2:0] code;
      begin
         is_column = (code == `CMD_RD) || (code == `CMD_WR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Command decode, registered on the rising edge.

   wire take = !cs_in_n;
   wire [2:0] pins = {ras_in_n, cas_in_n, we_in_n};
   wire act_low = !act_in_n;

   reg next_valid;

   // Next values of the captured fields.
   reg next_act;
   reg [2:0] next_code;
   reg [BA_W-1:0] next_bank;
   reg [BG_W-1:0] next_group;
   reg [2:0] next_mr_sel;
   reg [17:0] next_row;
   reg [9:0] next_col;
   reg [17:0] next_opcode;
   reg next_auto_pre;
   reg next_chop;
   reg next_pre_all;

   // Fields stand until the next selected command, so each default is the present value.
   always @* begin
      next_valid = take && asks_work(act_low, pins);
      next_act = cmd_act;
      next_code = cmd_code;
      next_bank = cmd_bank;
      next_group = cmd_group;
      next_mr_sel = mr_sel;
      next_row = row_addr;
      next_col = col_addr;
      next_opcode = opcode;
      next_auto_pre = auto_pre;
      next_chop = burst_chop;
      next_pre_all = pre_all;
      if (take) begin
         next_act = act_low;
         next_code = code_of(act_low, pins);
         next_bank = ba_in;
         next_group = bg_in;
         next_mr_sel = {bg_in[0], ba_in[1:0]};
         // Flags of an earlier command must not ride along with this one.
         next_auto_pre = 1'b0;
         next_chop = 1'b0;
         next_pre_all = 1'b0;
         if (act_low) begin
            next_row = row_of(addr_in, pins);
         end else if (is_column(pins)) begin
            next_col = addr_in[9:0];
            next_auto_pre = addr_in[`AP_BIT];
            next_chop = !addr_in[`BC_BIT];
         end else if (pins == `CMD_PRE) begin
            next_pre_all = addr_in[`AP_BIT];
         end else if (pins == `CMD_MRS) begin
            next_opcode = opcode_of(addr_in);
         end
      end
   end

   // The strobe lives apart from the fields: it drops after one cycle, they stand.
   always @(posedge clock) begin
      if (srst) begin
         cmd_valid <= 1'b0;
      end else begin
         cmd_valid <= next_valid;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         cmd_act <= 1'b0;
         cmd_code <= `CMD_NOP;
         cmd_bank <= {BA_W{1'b0}};
         cmd_group <= {BG_W{1'b0}};
         mr_sel <= 3'h0;
         row_addr <= 18'h00000;
         col_addr <= 10'h000;
         opcode <= 18'h00000;
         auto_pre <= 1'b0;
         burst_chop <= 1'b0;
         pre_all <= 1'b0;
      end else begin
         cmd_act <= next_act;
         cmd_code <= next_code;
         cmd_bank <= next_bank;
         cmd_group <= next_group;
         mr_sel <= next_mr_sel;
         row_addr <= next_row;
         col_addr <= next_col;
         opcode <= next_opcode;
         auto_pre <= next_auto_pre;
         burst_chop <= next_chop;
         pre_all <= next_pre_all;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Termination; the control pin is read only while its buffer is on.

   // The strobe pair is only terminated on the x8 part with its function enabled.
   wire strobe_term_ok = tdqs_en && (IS_X8 != 0);
   reg next_rtt_nom;
   reg next_rtt_tdqs;

   always @* begin
      // A disabled nominal setting makes the control pin of no effect at all.
      next_rtt_nom = odt_in && rtt_nom_en;
      next_rtt_tdqs = next_rtt_nom && strobe_term_ok;
   end

   always @(posedge clock) begin
      if (srst) begin
         rtt_nom_on <= 1'b0;
      end else begin
         rtt_nom_on <= next_rtt_nom;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         rtt_tdqs_on <= 1'b0;
      end else begin
         rtt_tdqs_on <= next_rtt_tdqs;
      end
   end

endmodule // ddr4_ca_decode

// [ddr4_ca_decode_sva.sv]
// Port checks for the command decoder.
module ddr4_ca_decode_sva (
   input wire logic clock, srst, cs_n, act_n, ras_n, cas_n, we_n, odt, // Inputs.
   input wire logic [17:0] addr, // Address.
   input wire logic rtt_nom_en, cmd_valid, cmd_act, auto_pre, burst_chop, pre_all, // Flags.
   input wire logic rtt_nom_on, clk_run, odt_buf_on, drv_on, // Levels.
   input wire logic [2:0] cmd_code, // Code.
   input wire logic [17:0] row_addr, // Row.
   input wire logic [1:0] power_state // State.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   wire take = !cs_n && clk_run && act_n;
   a_cs_masks: assert property (cs_n |=> !cmd_valid) else $error("select");
   a_cke_gates: assert property (!clk_run |=> !cmd_valid) else $error("gated");
   a_act_row: assert property (!cs_n && clk_run && !act_n |=> cmd_valid && cmd_act
      && row_addr[16:14] == $past({ras_n, cas_n, we_n})) else $error("row");
   a_cmd_code: assert property (take && {ras_n, cas_n, we_n} != 3'h7 |=> cmd_valid
      && !cmd_act && cmd_code == $past({ras_n, cas_n, we_n})) else $error("code");
   a_rw_bits: assert property (take && {ras_n, cas_n} == 2'h2 |=>
      auto_pre == $past(addr[10]) && burst_chop == !$past(addr[12])) else $error("rw");
   a_pre_all: assert property (take && {ras_n, cas_n, we_n} == 3'h2 |=>
      pre_all == $past(addr[10])) else $error("pre");
   a_odt_off: assert property (!rtt_nom_en |=> !rtt_nom_on) else $error("odt off");
   a_odt_on: assert property (odt && rtt_nom_en && odt_buf_on |=> rtt_nom_on)
      else $error("odt on");
   a_self_bufs: assert property (power_state == 2'h3 |-> !clk_run && !odt_buf_on)
      else $error("sr bufs");
   a_pd_bufs: assert property (power_state inside {2'h1, 2'h2} |->
      !clk_run && odt_buf_on && !drv_on) else $error("pd bufs");
endmodule // ddr4_ca_decode_sva
bind ddr4_ca_decode ddr4_ca_decode_sva u_sva (.*);

// [ddr4_ctrl_model.sv]
// Controller model driving the command, address and control pins.
module ddr4_ctrl_model (
   input wire logic clock, // Clock.
   output logic cke_pin, cs_n, act_n, ras_n, cas_n, we_n, odt, // Pins.
   output logic [17:0] addr, // Address.
   output logic [1:0] ba, bg // Bank, group.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cke_pin, odt, cs_n, act_n, ras_n, cas_n, we_n} = 7'h5f;
      {addr, ba, bg} = 22'h0;
   end
   // Clock enable moves only between commands, never inside an access.
   task automatic levels(input logic k, o);
      @(posedge clock);
      {cke_pin, odt} <= {k, o};
   endtask
   // Once deselected the pins show the inverse, so stale values never look valid.
   task automatic issue(input logic [4:0] c, input logic [17:0] a, input logic [1:0] b, g);
      @(posedge clock);
      {cs_n, act_n, ras_n, cas_n, we_n, addr, ba, bg} <= {c, a, b, g};
      @(posedge clock);
      {cs_n, act_n, ras_n, cas_n, we_n, addr, ba, bg} <= {1'b1, ~c[3:0], ~a, ~b, ~g};
   endtask
endmodule // ddr4_ctrl_model

// [tb_top.sv]
// Self-checking bench for the command decoder.
`include "ddr4_ca_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, srst = 1, rtt_nom_en = 0, tdqs_en = 0, any_bank_open = 0;
   logic self_refresh_req = 0;
   wire cke_pin, cs_n, act_n, ras_n, cas_n, we_n, odt, cmd_valid, cmd_act, auto_pre;
   wire burst_chop, pre_all, rtt_nom_on, rtt_tdqs_on, clk_run, odt_buf_on, drv_on;
   wire [17:0] addr, row_addr, opcode;
   wire [1:0] ba, bg, cmd_bank, cmd_group, power_state;
   wire [2:0] cmd_code, mr_sel;
   wire [9:0] col_addr;
   int err_count = 0, n_checks = 0, cycles = 0;
   ddr4_ctrl_model u_ddr4_ctrl_model (.*);
   ddr4_ca_decode u_ddr4_ca_decode (.*);
   initial forever #2.5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [17:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [4:0] c, input logic [17:0] a, input logic [1:0] b, g);
      u_ddr4_ctrl_model.issue(c, a, b, g);
      #1;
   endtask
   task automatic t_rdwr;
      cmd(5'h0d, 18'h00433, 2'h1, 2'h2);
      chk("rd", {1'b1, `CMD_RD}, {cmd_valid, cmd_code});
      chk("rd bits", 2'h3, {auto_pre, burst_chop});
      chk("bank", 4'h9, {cmd_group, cmd_bank});
      chk("col", 10'h033, col_addr);
      cmd(5'h0c, 18'h01000, 2'h0, 2'h0);
      chk("wr", {1'b1, `CMD_WR, 2'h0}, {cmd_valid, cmd_code, auto_pre, burst_chop});
      $display("t_rdwr done");
   endtask
   task automatic t_codes;
      logic [2:0] codes [4] = '{`CMD_MRS, `CMD_REF, `CMD_PRE, `CMD_ZQC};
      foreach (codes[i]) begin
         cmd({2'h1, codes[i]}, 18'h00400, 2'h2, 2'h1);
         chk("code", {1'b1, codes[i]}, {cmd_valid, cmd_code});
         if (codes[i] == `CMD_PRE) chk("pre all", 1, pre_all);
      end
      cmd(5'h08, 18'h00000, 2'h2, 2'h1);
      chk("mr sel", 3'h6, mr_sel);
      chk("opcode", 18'h0, opcode);
      cmd(5'h0a, 18'h00000, 2'h1, 2'h0);
      chk("pre one", 5'h01, {pre_all, cmd_group, cmd_bank});
      cmd(5'h1d, 18'h0, 2'h0, 2'h0);
      chk("deselect", 0, cmd_valid);
      $display("t_codes done");
   endtask
   task automatic t_act;
      cmd(5'h05, 18'h2a5a5, 2'h3, 2'h0);
      chk("act", 1, cmd_act);
      chk("row", {1'b1, 3'h5, 14'h25a5}, row_addr);
      $display("t_act done");
   endtask
   task automatic t_odt;
      @(posedge clock);
      {rtt_nom_en, tdqs_en} <= 2'h3;
      u_ddr4_ctrl_model.levels(1, 1);
      repeat (2) @(posedge clock);
      #1 chk("rtt", 2'h3, {rtt_nom_on, rtt_tdqs_on});
      @(posedge clock);
      rtt_nom_en <= 0;
      repeat (2) @(posedge clock);
      #1 chk("rtt off", 0, rtt_nom_on);
      $display("t_odt done");
   endtask
   task automatic t_power;
      logic [1:0] exp [3] = '{2'h2, 2'h3, 2'h1};
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         {any_bank_open, self_refresh_req} <= {i == 0, i == 1};
         u_ddr4_ctrl_model.levels(0, 0);
         for (int n = 0; n < 12 && power_state !== exp[i]; n++) @(posedge clock);
         chk("pd state", exp[i], power_state);
         cmd(5'h0d, 18'h0, 2'h0, 2'h0);
         chk("pd cmd", 0, cmd_valid);
         u_ddr4_ctrl_model.levels(1, 0);
         for (int n = 0; n < 12 && power_state !== 2'h0; n++) @(posedge clock);
         chk("exit", 0, power_state);
      end
      $display("t_power done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      srst <= 0;
      t_rdwr();
      t_codes();
      t_act();
      t_odt();
      t_power();
      results();
   end
endmodule // tb_top
